// [ccd_top.v]
// register wrapper for comparators 1, 2, 3 and 5 with input routing
`timescale 1ns/1ps
`include "ccd_defines.vh"

// What this block does
// - enable bit powers comparator and its converter
// - debounce code zero bypasses the filter
// - codes one to seven need longer stable time
// - non inverted: one when positive input higher
// - inverted: zero when positive input higher
// - filtered output bit is read only
// - comparator 4 positive input routing codes
// - comparator 3 negative input routing codes
// - comparator 2 converter and pin routing codes
// - comparator 1 negative input select bit
// - comparator 5 negative input routing codes
// - unimplemented select bits read zero
module ccd_top (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // raw comparator results: 0 = c1, 1 = c2, 2 = c3, 3 = c5
   input  wire [3:0]  cmp_result_i,
   // power control of comparators and their reference converters
   output reg  [3:0]  comparator_enable_o,
   output reg  [3:0]  converter_enable_o,
   // hysteresis window, two bits per comparator
   output reg  [7:0]  hysteresis_window_select_o,
   // filtered results
   output reg  [3:0]  filtered_output_o,
   // comparator 4 positive input, one hot
   output reg  [3:0]  comp4_pos_route_o,
   // comparator 3 negative input, one hot
   output reg  [3:0]  comp3_neg_route_o,
   // comparator 2 switches
   output reg         comp2_neg_converter_o,
   output reg         comp2_neg_pin_o,
   output reg         comp2_pos_converter_o,
   output reg         comp2_pos_pin_o,
   // comparator 1 negative input, one hot
   output reg  [1:0]  comp1_neg_route_o,
   // comparator 5 negative input, one hot
   output reg  [3:0]  comp5_neg_route_o
);

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   reg  [7:0] ctl_q [0:3];
   reg  [7:0] sel_a_q;
   reg  [7:0] sel_b_q;
   wire [3:0] filt;

   wire       req;
   wire       wr_en;
   reg  [2:0] wr_idx;
   reg        hit;
   reg  [7:0] rd_byte;
   integer    k;
   integer    m;

   assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en = req & wb_we_i & wb_sel_i[0];

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   always @* begin
      hit    = 1'b1;
      wr_idx = 3'h0;
      case (wb_adr_i)
         `CCD_ADR_CTL_C1: wr_idx = 3'h0;
         `CCD_ADR_CTL_C2: wr_idx = 3'h1;
         `CCD_ADR_CTL_C3: wr_idx = 3'h2;
         `CCD_ADR_CTL_C5: wr_idx = 3'h3;
         `CCD_ADR_SEL_A:  wr_idx = 3'h4;
         `CCD_ADR_SEL_B:  wr_idx = 3'h5;
         default:         hit    = 1'b0;
      endcase
   end

   // read data, filtered bit spliced into the control bytes
   always @* begin
      case (wr_idx)
         3'h0, 3'h1, 3'h2, 3'h3: begin
            rd_byte = ctl_q[wr_idx[1:0]] & `CCD_CTL_WMASK;
            rd_byte[`CCD_CTL_VOD] = filt[wr_idx[1:0]];
         end
         3'h4:    rd_byte = sel_a_q & `CCD_SELA_WMASK;
         3'h5:    rd_byte = sel_b_q & `CCD_SELB_WMASK;
         default: rd_byte = 8'h00;
      endcase
      if (!hit) begin
         rd_byte = 8'h00;
      end
   end

   // ------------------------------------------------------------
   // wishbone handshake: one wait state, unmapped reads as zero
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_byte};
         end
      end
   end

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (k = 0; k < 4; k = k + 1) begin
            ctl_q[k] <= `CCD_RST_CTL;
         end
         sel_a_q <= `CCD_RST_SEL;
         sel_b_q <= `CCD_RST_SEL;
      end else if (wr_en && hit) begin
         case (wr_idx)
            3'h4: sel_a_q <= wb_dat_i[7:0] & `CCD_SELA_WMASK;
            3'h5: sel_b_q <= wb_dat_i[7:0] & `CCD_SELB_WMASK;
            default: begin
               // filtered bit is never stored from the bus
               ctl_q[wr_idx[1:0]] <= wb_dat_i[7:0] & `CCD_CTL_WMASK;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // debounce clock enable
   // ------------------------------------------------------------
   reg [7:0] div_q;
   reg       tick_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         div_q  <= 8'h00;
         tick_q <= 1'b0;
      end else if (div_q == `CCD_DEB_DIV - 8'h01) begin
         div_q  <= 8'h00;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 8'h01;
         tick_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // per comparator: synchroniser, polarity and debounce
   // ------------------------------------------------------------
   reg [3:0] sync1_q;
   reg [3:0] sync2_q;

   // results are asynchronous to the clock
   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= cmp_result_i;
         sync2_q <= sync1_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_cmp
         wire [7:0] c = ctl_q[g];
         wire       pol;

         // inversion applied before filtering so timing is symmetric
         assign pol = sync2_q[g] ^ c[`CCD_CTL_INV];

         ccd_debounce u_deb (
            .clk_i             (clk_i),
            .rst_i             (rst_i),
            .enable_i          (c[`CCD_CTL_EN]),
            .tick_i            (tick_q),
            .debounce_select_i (c[`CCD_CTL_DB_HI:`CCD_CTL_DB_LO]),
            .sample_i          (pol),
            .filtered_q        (filt[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // output flops: power, hysteresis and filtered bits
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         comparator_enable_o        <= 4'h0;
         converter_enable_o         <= 4'h0;
         hysteresis_window_select_o <= 8'h00;
         filtered_output_o          <= 4'h0;
      end else begin
         for (m = 0; m < 4; m = m + 1) begin
            comparator_enable_o[m] <= ctl_q[m][`CCD_CTL_EN];
            converter_enable_o[m]  <= ctl_q[m][`CCD_CTL_EN];
            hysteresis_window_select_o[2*m]   <=
               ctl_q[m][`CCD_CTL_HYS_LO];
            hysteresis_window_select_o[2*m+1] <=
               ctl_q[m][`CCD_CTL_HYS_HI];
         end
         filtered_output_o <= filt;
      end
   end

   // ------------------------------------------------------------
   // input routing decode
   // ------------------------------------------------------------
   wire [1:0] c4_sel = sel_a_q[`CCD_SELA_C4_HI:`CCD_SELA_C4_LO];
   wire [1:0] c3_sel = sel_a_q[`CCD_SELA_C3_HI:`CCD_SELA_C3_LO];
   wire [1:0] c2_sel = sel_a_q[`CCD_SELA_C2_HI:`CCD_SELA_C2_LO];
   wire [1:0] c5_sel = sel_b_q[`CCD_SELB_C5_HI:`CCD_SELB_C5_LO];
   reg  [3:0] c4_hot;
   reg  [3:0] c3_hot;
   reg  [3:0] c5_hot;

   // two bit route codes to one hot switch enables
   always @* begin
      case (c4_sel)
         2'h0:    c4_hot = 4'h1;
         2'h1:    c4_hot = 4'h2;
         2'h2:    c4_hot = 4'h4;
         default: c4_hot = 4'h8;
      endcase
      case (c3_sel)
         2'h0:    c3_hot = 4'h1;
         2'h1:    c3_hot = 4'h2;
         2'h2:    c3_hot = 4'h4;
         default: c3_hot = 4'h8;
      endcase
      case (c5_sel)
         2'h0:    c5_hot = 4'h1;
         2'h1:    c5_hot = 4'h2;
         2'h2:    c5_hot = 4'h4;
         default: c5_hot = 4'h8;
      endcase
   end

   // bit order of one hot routes follows the code value:
   // c4: 0 c1 neg pin, 1 c2 pos pin, 2 c2 neg pin, 3 c4 pos pin
   // c3: 0 c0 pos pin, 1 c1 neg pin, 2 amplifier out, 3 c3 neg pin
   // c5: 0 c0 pos pin, 1 amplifier pos in, 2 amplifier out,
   //     3 c5 neg pin
   always @(posedge clk_i) begin
      if (rst_i) begin
         comp4_pos_route_o     <= 4'h1;
         comp3_neg_route_o     <= 4'h1;
         comp5_neg_route_o     <= 4'h1;
         comp1_neg_route_o     <= 2'h1;
         comp2_neg_converter_o <= 1'b1;
         comp2_neg_pin_o       <= 1'b0;
         comp2_pos_converter_o <= 1'b0;
         comp2_pos_pin_o       <= 1'b1;
      end else begin
         comp4_pos_route_o <= c4_hot;
         comp3_neg_route_o <= c3_hot;
         comp5_neg_route_o <= c5_hot;
         if (sel_a_q[`CCD_SELA_C1]) begin
            comp1_neg_route_o <= 2'h2;
         end else begin
            comp1_neg_route_o <= 2'h1;
         end
         case (c2_sel)
            2'h0: begin
               comp2_neg_converter_o <= 1'b1;
               comp2_neg_pin_o       <= 1'b0;
               comp2_pos_converter_o <= 1'b0;
               comp2_pos_pin_o       <= 1'b1;
            end
            2'h1: begin
               comp2_neg_converter_o <= 1'b0;
               comp2_neg_pin_o       <= 1'b1;
               comp2_pos_converter_o <= 1'b1;
               comp2_pos_pin_o       <= 1'b0;
            end
            default: begin
               comp2_neg_converter_o <= 1'b0;
               comp2_neg_pin_o       <= 1'b1;
               comp2_pos_converter_o <= 1'b0;
               comp2_pos_pin_o       <= 1'b1;
            end
         endcase
      end
   end

endmodule // ccd_top

// [ccd_defines.vh]
// constants for the comparator control and debounce block
`ifndef CCD_DEFINES_VH
`define CCD_DEFINES_VH

// byte addresses of the register words
`define CCD_ADR_CTL_C1      8'h00
`define CCD_ADR_CTL_C2      8'h04
`define CCD_ADR_CTL_C3      8'h08
`define CCD_ADR_CTL_C5      8'h0C
`define CCD_ADR_SEL_A       8'h10
`define CCD_ADR_SEL_B       8'h14

// control register fields
`define CCD_CTL_EN          7
`define CCD_CTL_HYS_HI      6
`define CCD_CTL_HYS_LO      5
`define CCD_CTL_VOD         4
`define CCD_CTL_INV         3
`define CCD_CTL_DB_HI       2
`define CCD_CTL_DB_LO       0
`define CCD_CTL_WMASK       8'hEF

// input select register a fields
`define CCD_SELA_C4_HI      7
`define CCD_SELA_C4_LO      6
`define CCD_SELA_C3_HI      5
`define CCD_SELA_C3_LO      4
`define CCD_SELA_C2_HI      3
`define CCD_SELA_C2_LO      2
`define CCD_SELA_C1         0
`define CCD_SELA_WMASK      8'hFD

// input select register b fields
`define CCD_SELB_C5_HI      1
`define CCD_SELB_C5_LO      0
`define CCD_SELB_WMASK      8'h03

// reset values
`define CCD_RST_CTL         8'h00
`define CCD_RST_SEL         8'h00

// debounce clock: system clock cycles per debounce period
`define CCD_DEB_DIV         8'h01
`define CCD_DEB_CNT_W       8

// ticks counted after the last change; the output moves at the
// upper end of each stability range
`define CCD_DEB_T1          8'h02
`define CCD_DEB_T2          8'h06
`define CCD_DEB_T3          8'h0E
`define CCD_DEB_T4          8'h1E
`define CCD_DEB_T5          8'h3E
`define CCD_DEB_T6          8'h7E
`define CCD_DEB_T7          8'hFE

`endif

// [ccd_debounce.v]
// debounce filter for one comparator result
`timescale 1ns/1ps
`include "ccd_defines.vh"

module ccd_debounce (
   // clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // control
   input  wire       enable_i,
   input  wire       tick_i,
   input  wire [2:0] debounce_select_i,
   // synchronised, polarity corrected result
   input  wire       sample_i,
   // filtered output
   output reg        filtered_q
);

   reg [`CCD_DEB_CNT_W-1:0] cnt_q;
   reg                      last_q;
   reg [`CCD_DEB_CNT_W-1:0] target;

   // ticks of stability to count after the last seen level
   always @* begin
      case (debounce_select_i)
         3'h1:    target = `CCD_DEB_T1;
         3'h2:    target = `CCD_DEB_T2;
         3'h3:    target = `CCD_DEB_T3;
         3'h4:    target = `CCD_DEB_T4;
         3'h5:    target = `CCD_DEB_T5;
         3'h6:    target = `CCD_DEB_T6;
         3'h7:    target = `CCD_DEB_T7;
         default: target = 8'h00;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         cnt_q      <= 8'h00;
         last_q     <= 1'b0;
         filtered_q <= 1'b0;
      end else begin
         last_q <= sample_i;
         if (debounce_select_i == 3'h0) begin
            filtered_q <= sample_i;
            cnt_q      <= 8'h00;
         end else if (sample_i != last_q) begin
            // change seen mid period: hence the one period spread
            cnt_q <= 8'h00;
         end else if (cnt_q == target) begin
            filtered_q <= last_q;
         end else if (tick_i) begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end

endmodule // ccd_debounce

// [ccd_top_chk.sv]
// assertion checker for the comparator control block
`timescale 1ns/1ps
module ccd_top_chk (
   // clock and reset
   input logic        clk_i,
   input logic        rst_i,
   // bus
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_we_i,
   input logic [7:0]  wb_adr_i,
   input logic [3:0]  wb_sel_i,
   input logic [31:0] wb_dat_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   // comparator side
   input logic [3:0]  comparator_enable_o,
   input logic [3:0]  converter_enable_o,
   input logic [3:0]  filtered_output_o,
   input logic [3:0]  comp4_pos_route_o,
   input logic [3:0]  comp3_neg_route_o,
   input logic [3:0]  comp5_neg_route_o,
   input logic        comp2_neg_converter_o,
   input logic        comp2_neg_pin_o,
   input logic        comp2_pos_converter_o,
   input logic        comp2_pos_pin_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic wacc;
   assign wacc = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   chk_ack_wait: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_en_pair: assert property (
      comparator_enable_o == converter_enable_o)
      else $error("enable outputs disagree");
   chk_en_write: assert property (wacc && wb_adr_i == 8'h00 |->
      ##2 comparator_enable_o[0] == $past(wb_dat_i[7], 2))
      else $error("enable not taken from write");
   chk_c4_route: assert property (wacc && wb_adr_i == 8'h10 |->
      ##2 comp4_pos_route_o == 4'h1 << $past(wb_dat_i[7:6], 2))
      else $error("comparator 4 route wrong");
   chk_route_onehot: assert property (
      $onehot(comp3_neg_route_o) && $onehot(comp5_neg_route_o))
      else $error("route not one hot");
   chk_c2_switch: assert property (
      comp2_pos_pin_o != comp2_pos_converter_o &&
      comp2_neg_pin_o != comp2_neg_converter_o &&
      !(comp2_pos_converter_o && comp2_neg_converter_o))
      else $error("comparator 2 switches illegal");
   chk_selb_zero: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i == 8'h14 |-> wb_dat_o[31:2] == 30'h0)
      else $error("unused select bits not zero");
   chk_off_zero: assert property (!comparator_enable_o[0] [*3] |->
      !filtered_output_o[0])
      else $error("disabled comparator output set");
   cover property (wacc && wb_adr_i == 8'h10);
   cover property ($rose(filtered_output_o[0]));
   cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h18);
endmodule // ccd_top_chk

bind ccd_top ccd_top_chk chk_i (
   .clk_i                 (clk_i),
   .rst_i                 (rst_i),
   .wb_cyc_i              (wb_cyc_i),
   .wb_stb_i              (wb_stb_i),
   .wb_we_i               (wb_we_i),
   .wb_adr_i              (wb_adr_i),
   .wb_sel_i              (wb_sel_i),
   .wb_dat_i              (wb_dat_i),
   .wb_dat_o              (wb_dat_o),
   .wb_ack_o              (wb_ack_o),
   .comparator_enable_o   (comparator_enable_o),
   .converter_enable_o    (converter_enable_o),
   .filtered_output_o     (filtered_output_o),
   .comp4_pos_route_o     (comp4_pos_route_o),
   .comp3_neg_route_o     (comp3_neg_route_o),
   .comp5_neg_route_o     (comp5_neg_route_o),
   .comp2_neg_converter_o (comp2_neg_converter_o),
   .comp2_neg_pin_o       (comp2_neg_pin_o),
   .comp2_pos_converter_o (comp2_pos_converter_o),
   .comp2_pos_pin_o       (comp2_pos_pin_o)
);

// [ccd_cmp_model.sv]
// behavioural model of the four analog comparator cores
`timescale 1ns/1ps
module ccd_cmp_model (
   // clock
   input  logic        clk_i,
   // power and input levels, one byte per comparator
   input  logic [3:0]  enable_i,
   input  logic [31:0] vpos_i,
   input  logic [31:0] vneg_i,
   // raw results
   output logic [3:0]  result_o
);
   logic [3:0] noise_q = 4'h5;
   // a powered down core gives garbage, never its last value
   always @(posedge clk_i) noise_q <= ~noise_q;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         result_o[i] = enable_i[i] ? (vpos_i[8*i+:8] > vneg_i[8*i+:8])
                                   : noise_q[i];
      end
   end
endmodule // ccd_cmp_model

// [tb_ccd_top.sv]
// self-checking testbench for the comparator control block
`timescale 1ns/1ps
module tb_ccd_top;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i, msa, msb, hys;
   logic [3:0]  wb_sel_i, cmp_result_i, en, cen, filt, r4, r3, r5;
   logic [31:0] wb_dat_i, wb_dat_o, vpos, vneg, q;
   logic [1:0]  r1;
   logic        c2nc, c2np, c2pc, c2pp, inv;
   logic [7:0]  mctl [4];
   integer      failures = 0, n_checks = 0, seed = 32'hb96ddb7d;
   int          k, n, c, p, idx;

   ccd_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_result_i,
      .comparator_enable_o(en), .converter_enable_o(cen),
      .hysteresis_window_select_o(hys), .filtered_output_o(filt),
      .comp4_pos_route_o(r4), .comp3_neg_route_o(r3),
      .comp2_neg_converter_o(c2nc), .comp2_neg_pin_o(c2np),
      .comp2_pos_converter_o(c2pc), .comp2_pos_pin_o(c2pp),
      .comp1_neg_route_o(r1), .comp5_neg_route_o(r5));
   ccd_cmp_model far (.clk_i, .enable_i(en), .vpos_i(vpos), .vneg_i(vneg),
      .result_o(cmp_result_i));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // -------------------------------------------------------------
   // bus tasks and reference model
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      if (failures == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic wb(input logic w, input int i, input logic [7:0] d,
                     input logic s, output logic [31:0] rd);
      int t;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= 8'(i * 4);
      wb_dat_i <= {24'h0, d};
      wb_sel_i <= {3'h0, s};
      for (t = 0; t < 20; t++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (t == 20) begin
         failures++;
         test_done();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input int i, input logic [7:0] d, input logic s);
      wb(1'b1, i, d, s, q);
      if (s && i < 4) mctl[i] = d & 8'hEF;
      if (s && i == 4) msa = d & 8'hFD;
      if (s && i == 5) msb = d & 8'h03;
   endtask

   // status bit is the raw result, inverted on request, only when powered
   function automatic logic [7:0] exp_rd(input int i);
      if (i < 4) return mctl[i] | {3'h0, mctl[i][7] &
         ((vpos[8*i+:8] > vneg[8*i+:8]) ^ mctl[i][3]), 4'h0};
      if (i == 4) return msa;
      if (i == 5) return msb;
      return 8'h00;
   endfunction

   task automatic check_all;
      logic [7:0] e;
      for (int i = 0; i < 7; i++) begin
         wb(1'b0, i, 8'h00, 1'b0, q);
         e = exp_rd(i);
         chk(q, {24'h0, e});
         if (i < 4) chk(32'(filt[i]), 32'(e[4]));
      end
      chk({en, cen}, {2{mctl[3][7], mctl[2][7],
         mctl[1][7], mctl[0][7]}});
      chk(hys, {mctl[3][6:5], mctl[2][6:5], mctl[1][6:5], mctl[0][6:5]});
      chk({r4, r3, r5, r1}, {4'h1 << msa[7:6], 4'h1 << msa[5:4],
         4'h1 << msb[1:0], msa[0] ? 2'h2 : 2'h1});
      chk({c2nc, c2np, c2pc, c2pp},
         {msa[3:2] == 2'h0, msa[3:2] != 2'h0,
         msa[3:2] == 2'h1, msa[3:2] != 2'h1});
   endtask

   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      vpos = 32'h0;
      vneg = 32'h80808080;
      msa = 8'h00;
      msb = 8'h00;
      mctl = '{8'h00, 8'h00, 8'h00, 8'h00};
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      check_all();
      // every routing code, unused select bits written as ones too
      for (k = 0; k < 4; k++) begin
         wr(4, 8'(k * 8'h55), 1'b1);
         wr(5, 8'(k * 8'h55), 1'b1);
         check_all();
      end
      // random traffic, unmapped word and dropped byte lane included
      repeat (24) begin
         idx = $random(seed);
         wr((idx & 32'h7FFFFFFF) % 7, 8'($random(seed)), 1'($random(seed)));
         repeat (300) @(posedge clk_i);
         check_all();
      end
      // delay of every debounce code, short glitches rejected
      for (k = 0; k < 8; k++) begin
         c = k % 4;
         inv = k[1];
         p = 1 << (k + 1);
         wr(c, 8'(8'h80 | (inv << 3) | k), 1'b1);
         vpos[8*c+:8] <= 8'h00;
         repeat (300) @(posedge clk_i);
         check_all();
         if (k >= 2) begin
            repeat (2) begin
               vpos[8*c+:8] <= 8'hFF;
               repeat (p - 3) @(posedge clk_i);
               vpos[8*c+:8] <= 8'h00;
               @(posedge clk_i);
            end
            repeat (10) @(posedge clk_i);
            chk(32'(filt[c]), 32'(inv));
         end
         vpos[8*c+:8] <= 8'hFF;
         for (n = 1; n < 600; n++) begin
            @(posedge clk_i);
            if (filt[c] !== inv) break;
         end
         if (n == 600) begin
            failures++;
            test_done();
         end
         // two sync flops, output flop and sampling edge around the filter
         if (k == 0) chk(n, 5);
         else chk(32'(n >= p + 3 && n <= p + 4), 1);
         repeat (20) @(posedge clk_i);
         check_all();
      end
      test_done();
   end
endmodule // tb_ccd_top
